/* rtl/irqap_ctrl.sv */
`timescale 1ns/1ps
`include "irqap_defines.svh"

module irqap_ctrl #(
    parameter int N_SRC = 8
) (
    input  wire logic               i_clock,
    input  wire logic               i_nrst,
    input  wire logic [N_SRC-1:0]   i_source_request_flag,
    input  wire logic [N_SRC-1:0]   i_source_mask_flag,
    input  wire logic [N_SRC-1:0]   i_source_priority_bit0,
    input  wire logic [N_SRC-1:0]   i_source_priority_bit1,
    input  wire logic               i_instr_done,
    input  wire logic               i_software_trap_instr,
    input  wire logic               i_irq_return_instr,
    input  wire logic               i_trap_return_instr,
    input  wire logic               i_enable_irq_instr,
    input  wire logic               i_disable_irq_instr,
    input  wire logic               i_status_pop_instr,
    input  wire logic               i_status_write,
    input  wire logic               i_skip_instr,
    input  wire logic               i_flag_reg_write,
    input  wire logic [7:0]         i_status_wdata,
    input  wire logic [19:0]        i_pc,
    input  wire logic [19:0]        i_return_pc,
    input  wire logic [15:0]        i_vector_data,
    output logic                    o_busy,
    output logic                    o_stack_push,
    output logic [19:0]             o_stack_wdata,
    output logic                    o_vector_rd,
    output logic [19:0]             o_vector_addr,
    output logic                    o_pc_load,
    output logic [19:0]             o_pc_value,
    output logic [N_SRC-1:0]        o_clear_request,
    output logic [7:0]              o_processor_status_word,
    output logic                    o_trap_active
);

    localparam int IDX_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;
    localparam logic [4:0] LAT_WAIT = 5'(`IRQAP_LAT_WAIT);

    irqap_pkg::irqap_state_t state_ff;
    irqap_pkg::irqap_state_t nxt_state;

    logic [7:0]         stat_ff;
    logic               trap_seq_ff;
    logic               trap_active_ff;
    logic [1:0]         lvl_ff;
    logic [IDX_W-1:0]   idx_ff;
    logic [4:0]         lat_cnt_ff;
    logic [N_SRC-1:0]   cand;
    logic [1:0]         src_lvl [N_SRC];
    logic               win_valid;
    logic [IDX_W-1:0]   win_idx;
    logic [1:0]         win_lvl;
    logic               hold_now;
    logic               take_trap;
    logic               take_mask;
    logic               global_irq_enable_flag;
    logic [1:0]         isp;
    logic [1:0]         svc_code;

    assign global_irq_enable_flag = stat_ff[`IRQAP_ENA_BIT];
    assign isp = {stat_ff[`IRQAP_SVC1_BIT], stat_ff[`IRQAP_SVC0_BIT]};

    // level 0 and 1 share code 00, others drop by one
    assign svc_code = (lvl_ff == 2'h0) ? `IRQAP_ISP_LVL01 : (lvl_ff - 2'h1);

    // per-source candidacy and level; level code equals the priority bits
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_src
            assign cand[g]    = i_source_request_flag[g] & ~i_source_mask_flag[g];
            assign src_lvl[g] = {i_source_priority_bit1[g], i_source_priority_bit0[g]};
        end
    endgenerate

    // arbiter: lowest level code wins, ties go to the lower index
    always_comb begin
        win_valid = 1'b0;
        win_idx   = '0;
        win_lvl   = 2'h3;
        for (int i = 0; i < N_SRC; i++) begin
            if (cand[i] && (!win_valid || (src_lvl[i] < win_lvl))) begin
                win_valid = 1'b1;
                win_idx   = IDX_W'(i);
                win_lvl   = src_lvl[i];
            end
        end
    end

    // instructions after which taking waits one more instruction
    assign hold_now = i_status_write | i_status_pop_instr | i_irq_return_instr
                    | i_trap_return_instr | i_enable_irq_instr | i_disable_irq_instr
                    | i_skip_instr | i_flag_reg_write;

    // the trap instruction ignores enable, mask and level
    assign take_trap = (state_ff == irqap_pkg::st_idle) && i_instr_done
                     && i_software_trap_instr;

    // a return also holds, so one interrupted instruction always runs first
    assign take_mask = (state_ff == irqap_pkg::st_idle) && i_instr_done && !hold_now
                     && !i_software_trap_instr && win_valid
                     && global_irq_enable_flag
                     && (trap_active_ff || (win_lvl <= isp))
                     && (lat_cnt_ff >= LAT_WAIT);

    // latency counter: saturating, restarts whenever no candidate stands
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            lat_cnt_ff <= 5'h00;
        end else if (!win_valid) begin
            lat_cnt_ff <= 5'h00;
        end else if (lat_cnt_ff < LAT_WAIT) begin
            lat_cnt_ff <= lat_cnt_ff + 5'h01;
        end
    end

    // sequencer: fixed five-clock path from decision to pc load
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            irqap_pkg::st_idle: begin
                if (take_trap || take_mask) begin
                    nxt_state = irqap_pkg::st_push_sts;
                end
            end
            irqap_pkg::st_push_sts: begin
                nxt_state = irqap_pkg::st_push_pc;
            end
            irqap_pkg::st_push_pc: begin
                nxt_state = irqap_pkg::st_vec_rd;
            end
            irqap_pkg::st_vec_rd: begin
                nxt_state = irqap_pkg::st_vec_load;
            end
            irqap_pkg::st_vec_load: begin
                nxt_state = irqap_pkg::st_idle;
            end
            default: begin
                nxt_state = irqap_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= irqap_pkg::st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // latch what was taken; nothing else is judged while the sequence runs
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            trap_seq_ff <= 1'b0;
            lvl_ff      <= 2'h0;
            idx_ff      <= '0;
        end else if (take_trap || take_mask) begin
            trap_seq_ff <= take_trap;
            lvl_ff      <= win_lvl;
            idx_ff      <= win_idx;
        end
    end

    // trap-in-service flag, ended only by the trap return
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            trap_active_ff <= 1'b0;
        end else if (take_trap) begin
            trap_active_ff <= 1'b1;
        end else if (i_instr_done && i_trap_return_instr) begin
            trap_active_ff <= 1'b0;
        end
    end

    // status word; the sequencer's update wins over instruction writes
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_ff <= `IRQAP_STAT_RESET;
        end else if (state_ff == irqap_pkg::st_push_pc) begin
            stat_ff[`IRQAP_ENA_BIT] <= 1'b0;
            if (!trap_seq_ff) begin
                // a trap keeps the serviced level as it was
                stat_ff[`IRQAP_SVC1_BIT] <= svc_code[1];
                stat_ff[`IRQAP_SVC0_BIT] <= svc_code[0];
            end
        end else if (i_instr_done && (i_irq_return_instr || i_trap_return_instr
                                      || i_status_pop_instr || i_status_write)) begin
            stat_ff <= i_status_wdata;
        end else if (i_instr_done && i_enable_irq_instr) begin
            stat_ff[`IRQAP_ENA_BIT] <= 1'b1;
        end else if (i_instr_done && i_disable_irq_instr) begin
            stat_ff[`IRQAP_ENA_BIT] <= 1'b0;
        end
    end

    // stack pushes: status word first, then the pc
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stack_push  <= 1'b0;
            o_stack_wdata <= 20'h00000;
        end else if (state_ff == irqap_pkg::st_push_sts) begin
            o_stack_push  <= 1'b1;
            o_stack_wdata <= {12'h000, stat_ff};
        end else if (state_ff == irqap_pkg::st_push_pc) begin
            o_stack_push  <= 1'b1;
            o_stack_wdata <= i_pc;
        end else begin
            o_stack_push  <= 1'b0;
        end
    end

    // request flag clear for the taken source, one pulse
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_clear_request <= '0;
        end else if (state_ff == irqap_pkg::st_push_sts && !trap_seq_ff) begin
            o_clear_request <= N_SRC'(1) << idx_ff;
        end else begin
            o_clear_request <= '0;
        end
    end

    // vector table read: fixed trap entry or per-source entry
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vector_rd   <= 1'b0;
            o_vector_addr <= 20'h00000;
        end else if (state_ff == irqap_pkg::st_push_pc) begin
            o_vector_rd   <= 1'b1;
            if (trap_seq_ff) begin
                o_vector_addr <= `IRQAP_TRAP_VEC;
            end else begin
                o_vector_addr <= `IRQAP_VEC_BASE + (20'(idx_ff) * `IRQAP_VEC_STEP);
            end
        end else begin
            o_vector_rd   <= 1'b0;
        end
    end

    // pc load: vector on taking, saved pc on either return
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pc_load  <= 1'b0;
            o_pc_value <= 20'h00000;
        end else if (state_ff == irqap_pkg::st_vec_load) begin
            o_pc_load  <= 1'b1;
            o_pc_value <= {4'h0, i_vector_data};
        end else if (i_instr_done && (i_irq_return_instr || i_trap_return_instr)) begin
            o_pc_load  <= 1'b1;
            o_pc_value <= i_return_pc;
        end else begin
            o_pc_load  <= 1'b0;
        end
    end

    // mirrors for the core
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_busy                  <= 1'b0;
            o_processor_status_word <= `IRQAP_STAT_RESET;
            o_trap_active           <= 1'b0;
        end else begin
            o_busy                  <= (nxt_state != irqap_pkg::st_idle);
            o_processor_status_word <= stat_ff;
            o_trap_active           <= trap_active_ff;
        end
    end

    // checks
    trap_always_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        take_trap |=> state_ff == irqap_pkg::st_push_sts && trap_seq_ff)
        else $error("trap not taken");

    need_enable_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $rose(state_ff == irqap_pkg::st_push_sts) && !trap_seq_ff
        |-> $past(global_irq_enable_flag))
        else $error("maskable taken with enable clear");

    cand_only_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        win_valid |-> i_source_request_flag[win_idx] && !i_source_mask_flag[win_idx])
        else $error("winner is not a candidate");

    push_order_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_push_sts
        |=> o_stack_push && o_stack_wdata == {12'h000, $past(stat_ff)} ##1 o_stack_push)
        else $error("status word not pushed before pc");

    enable_drop_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_push_pc |=> !global_irq_enable_flag)
        else $error("enable not cleared on taking");

    trap_vector_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_push_pc && trap_seq_ff
        |=> o_vector_rd && o_vector_addr == `IRQAP_TRAP_VEC)
        else $error("trap vector wrong");

    hold_defer_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_idle && i_instr_done && hold_now && !i_software_trap_instr
        |=> state_ff == irqap_pkg::st_idle)
        else $error("taken after a hold instruction");

    level_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $rose(state_ff == irqap_pkg::st_push_sts) && !trap_seq_ff
        |-> $past(trap_active_ff) || lvl_ff <= $past(isp))
        else $error("lower level nested");

    lat_floor_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        take_mask |-> lat_cnt_ff >= LAT_WAIT ##5 o_pc_load)
        else $error("service started too early or late");

    clear_req_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_push_sts && !trap_seq_ff
        |=> o_clear_request == (N_SRC'(1) << idx_ff))
        else $error("request flag not cleared");

    // the core stalls on busy, so it must cover every sequence state
    busy_span_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff != irqap_pkg::st_idle |-> o_busy)
        else $error("busy low during a sequence");

    ret_reload_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_ff == irqap_pkg::st_idle && i_instr_done && i_irq_return_instr
        |=> o_pc_load && o_pc_value == $past(i_return_pc) && stat_ff == $past(i_status_wdata))
        else $error("return did not restore pc and status");

endmodule : irqap_ctrl

/* rtl/irqap_defines.svh */
`ifndef IRQAP_DEFINES_SVH
`define IRQAP_DEFINES_SVH

// status word layout and reset value
`define IRQAP_STAT_RESET    8'h06
`define IRQAP_ENA_BIT       7
`define IRQAP_SVC1_BIT      2
`define IRQAP_SVC0_BIT      1

// serviced-level codes
`define IRQAP_ISP_NONE      2'h3
`define IRQAP_ISP_LVL01     2'h0

// vector table
`define IRQAP_TRAP_VEC      20'h0007e
`define IRQAP_VEC_BASE      20'h00004
`define IRQAP_VEC_STEP      20'h00002

// request-to-service latency, in cpu clocks
`define IRQAP_ACK_MIN_CLK   9
`define IRQAP_ACK_MAX_CLK   16
// clocks from the taking boundary to the pc load pulse
`define IRQAP_SEQ_CLK       5
`define IRQAP_LAT_WAIT      (`IRQAP_ACK_MIN_CLK - `IRQAP_SEQ_CLK)

`endif

/* rtl/irqap_pkg.sv */
package irqap_pkg;

    // acknowledge sequencer, one-hot
    typedef enum logic [4:0] {
        st_idle     = 5'h01,
        st_push_sts = 5'h02,
        st_push_pc  = 5'h04,
        st_vec_rd   = 5'h08,
        st_vec_load = 5'h10
    } irqap_state_t;

endpackage : irqap_pkg

/* tb/irqap_core_model.sv */
`timescale 1ns/1ps
// core side: keeps the last two stack pushes and answers vector table reads
module irqap_core_model (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_stack_push,
    input  wire logic [19:0] i_stack_wdata,
    input  wire logic        i_vector_rd,
    input  wire logic [19:0] i_vector_addr,
    output logic      [19:0] o_stack0,
    output logic      [19:0] o_stack1,
    output logic      [15:0] o_vector_data
);
    // older of the two pushes ends up in stack0
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stack0 <= 20'h00000;
            o_stack1 <= 20'h00000;
        end else if (i_stack_push) begin
            o_stack0 <= o_stack1;
            o_stack1 <= i_stack_wdata;
        end
    end
    // word valid only the cycle after a read; toggles otherwise so a late sample shows
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vector_data <= 16'h0000;
        end else if (i_vector_rd) begin
            o_vector_data <= i_vector_addr[15:0] ^ 16'h3c00;
        end else begin
            o_vector_data <= ~o_vector_data;
        end
    end
endmodule : irqap_core_model

/* tb/tb_irq_acknowledge_priority_nesting.sv */
`timescale 1ns/1ps
module tb_irq_acknowledge_priority_nesting;
    localparam int N = 8;
    localparam logic [19:0] PC_NOW = 20'h2b4c6;
    localparam logic [19:0] PC_RET = 20'h1a2b3;
    // levels: src0 0, src1 1, src2 2, src3 3, src4 3, src5 0, src6 0, src7 2
    localparam logic [7:0] PRI0 = 8'h1a;
    localparam logic [7:0] PRI1 = 8'h9c;
    // strobe order: trap, irq return, trap return, enable, disable, pop, write, skip, flag
    localparam logic [8:0] K_TRAP = 9'h100, K_IRQRET = 9'h080, K_TRAPRET = 9'h040;
    localparam logic [8:0] K_ON = 9'h020, K_OFF = 9'h010, K_POP = 9'h008;
    localparam logic [8:0] K_WR = 9'h004, K_SKIP = 9'h002, K_FLAG = 9'h001;
    logic          i_clock, i_nrst, done, busy, push, vrd, pc_load, trap_act;
    logic [8:0]    kind;
    logic [N-1:0]  req, mask, clr;
    logic [7:0]    wdata, status_word;
    logic [15:0]   vdata;
    logic [19:0]   stack0, stack1, swd, vaddr, pc_val;
    int            n_errors, n_checks;

    irqap_ctrl #(.N_SRC(N)) irqap_ctrl_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_source_request_flag(req),
        .i_source_mask_flag(mask), .i_source_priority_bit0(PRI0),
        .i_source_priority_bit1(PRI1), .i_instr_done(done),
        .i_software_trap_instr(kind[8]), .i_irq_return_instr(kind[7]),
        .i_trap_return_instr(kind[6]), .i_enable_irq_instr(kind[5]),
        .i_disable_irq_instr(kind[4]), .i_status_pop_instr(kind[3]),
        .i_status_write(kind[2]), .i_skip_instr(kind[1]), .i_flag_reg_write(kind[0]),
        .i_status_wdata(wdata), .i_pc(PC_NOW), .i_return_pc(PC_RET), .i_vector_data(vdata),
        .o_busy(busy), .o_stack_push(push), .o_stack_wdata(swd), .o_vector_rd(vrd),
        .o_vector_addr(vaddr), .o_pc_load(pc_load), .o_pc_value(pc_val),
        .o_clear_request(clr), .o_processor_status_word(status_word), .o_trap_active(trap_act)
    );
    irqap_core_model irqap_core_model_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_stack_push(push), .i_stack_wdata(swd),
        .i_vector_rd(vrd), .i_vector_addr(vaddr), .o_stack0(stack0), .o_stack1(stack1),
        .o_vector_data(vdata)
    );

    initial i_clock = 1'b0;
    always #25 i_clock = ~i_clock;

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // one instruction boundary; strobes only live for that one edge
    task automatic bound(input logic [8:0] k);
        @(negedge i_clock);
        kind = k;
        done = 1'b1;
        @(negedge i_clock);
        kind = 9'h000;
        done = 1'b0;
    endtask : bound

    // boundary that must leave every request pending
    task automatic no_take(input logic [8:0] k);
        logic b;
        b = 1'b0;
        bound(k);
        repeat (7) begin
            @(negedge i_clock);
            b |= busy;
        end
        chk(20'(b), 20'h0);
    endtask : no_take

    // full acknowledge sequence: timing, vector, pushes, flag clear
    task automatic serve(input logic [8:0] k, input logic [19:0] va, input logic [7:0] sw0,
                         input logic [N-1:0] cl);
        int k_n;
        logic [N-1:0] cs;
        logic [19:0] sa;
        k_n = 1; // bound returns half a clock after the decision edge
        cs = '0;
        sa = 20'h0;
        bound(k);
        chk(20'(busy), 20'h1);
        while (pc_load !== 1'b1 && k_n < 12) begin
            @(negedge i_clock);
            k_n++;
            cs |= clr;
            if (vrd === 1'b1) sa = vaddr;
        end
        if (k_n >= 12) begin
            n_errors++;
            report_and_stop();
        end
        chk(20'(k_n), 20'h5);
        chk(sa, va);
        chk(pc_val, {4'h0, va[15:0] ^ 16'h3c00});
        chk(20'(cs), 20'(cl));
        chk(stack0, 20'(sw0));
        chk(stack1, PC_NOW);
        req = req & ~cs;
    endtask : serve

    // return: pc reload, status restore, no sequence at that boundary
    task automatic ret(input logic [8:0] k, input logic [7:0] w);
        logic b;
        logic [19:0] pv;
        b = 1'b0;
        pv = 20'h0;
        wdata = w;
        bound(k);
        repeat (4) begin
            if (pc_load === 1'b1) pv = pc_val;
            b |= busy;
            @(negedge i_clock);
        end
        chk(pv, PC_RET);
        chk(20'(b), 20'h0);
        chk(20'(status_word), 20'(w));
    endtask : ret

    // enable, mask and latency gating of one level 2 source
    task automatic t_gate();
        req = 8'h04;
        repeat (6) @(negedge i_clock);
        no_take(9'h000);
        no_take(K_ON);
        chk(20'(status_word), 20'h86);
        mask = 8'h04;
        repeat (6) @(negedge i_clock);
        no_take(9'h000);
        mask = 8'h00;
        no_take(9'h000);
        no_take(K_FLAG);
        serve(9'h000, 20'h00008, 8'h86, 8'h04);
        chk(20'(status_word), 20'h02);
    endtask : t_gate

    // nesting under a level 2 handler, lower level waits for the return
    task automatic t_nest();
        req = req | 8'h0a;
        repeat (6) @(negedge i_clock);
        no_take(9'h000);
        no_take(K_ON);
        serve(9'h000, 20'h00006, 8'h82, 8'h02);
        chk(20'(status_word), 20'h00);
        no_take(K_ON);
        no_take(9'h000);
        ret(K_IRQRET, 8'h86);
        serve(9'h000, 20'h0000a, 8'h86, 8'h08);
        chk(20'(status_word), 20'h04);
    endtask : t_nest

    // simultaneous requests: level first, then lowest index
    task automatic t_arb();
        wdata = 8'h86;
        req = req | 8'h66;
        no_take(K_WR);
        chk(20'(status_word), 20'h86);
        serve(9'h000, 20'h0000e, 8'h86, 8'h20);
        chk(20'(status_word), 20'h00);
    endtask : t_arb

    // write sets enable while it is clear; pop, skip, enable and flag holds each defer the pending winner by one instruction
    task automatic t_hold();
        logic [8:0] h [5];
        h = '{K_WR, K_POP, K_SKIP, K_ON, K_FLAG};
        foreach (h[i]) no_take(h[i]);
        serve(9'h000, 20'h00010, 8'h86, 8'h40);
    endtask : t_hold

    // trap with interrupts off, then a level 1 nest admitted by the trap
    task automatic t_trap();
        no_take(K_ON);
        no_take(K_OFF);
        chk(20'(status_word), 20'h00);
        serve(K_TRAP | K_SKIP, 20'h0007e, 8'h00, 8'h00);
        chk(20'(trap_act), 20'h1);
        no_take(K_ON);
        serve(9'h000, 20'h00006, 8'h80, 8'h02);
        ret(K_IRQRET, 8'h80);
        ret(K_TRAPRET, 8'h06);
        chk(20'(trap_act), 20'h0);
    endtask : t_trap

    initial begin
        n_errors = 0;
        n_checks = 0;
        i_nrst = 1'b0;
        done = 1'b0;
        kind = 9'h000;
        req = 8'h00;
        mask = 8'h00;
        wdata = 8'h06;
        repeat (6) @(negedge i_clock);
        i_nrst = 1'b1;
        chk(20'(status_word), 20'h06);
        t_gate();
        t_nest();
        t_arb();
        t_hold();
        t_trap();
        report_and_stop();
    end
endmodule : tb_irq_acknowledge_priority_nesting
